// ---- rtl/dram_mode_register_file.sv ----
// Mode register file: write-only configuration, read-only status/identity.
// Assumes commands already decoded and synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module dram_mode_register_file (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic mode_reg_write_cmd,
  input wire logic mode_reg_read_cmd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] write_data,
  input wire logic [2:0] refresh_multiplier_in,
  input wire logic zq_pin_to_supply,
  input wire logic zq_pin_to_ground,
  input wire logic [2:0] burst_start_col,
  input wire logic burst_step,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic strobe_t,
  output logic strobe_c,
  output logic auto_init_pending,
  output logic [2:0] write_recovery_cycles_o,
  output logic [4:0] wr_recovery_count,
  output logic [3:0] read_latency,
  output logic [3:0] write_latency,
  output logic write_level_en,
  output logic [3:0] drive_strength_sel,
  output logic use_factory_trim,
  output logic cal_start,
  output logic [7:0] cal_code,
  output logic [1:0] data_termination_sel,
  output logic powerdown_termination_keep,
  output logic [7:0] bank_refresh_block,
  output logic [7:0] segment_refresh_block,
  output logic ca_training,
  output logic [2:0] burst_col,
  output logic derate_needed
);
  import mode_reg_pkg::*;

  feature_one_t feat1_r;
  feature_two_t feat2_r;
  logic [1:0] selftest_r;
  logic [2:0] mult_r;
  logic tuf_r;
  logic [15:0] init_cnt_r;
  logic [2:0] burst_idx_r;
  logic [7:0] rd_nxt;
  logic soft_rst;
  logic wr_hit;

  default clocking dcb @(posedge mclk);
  endclocking

  function automatic logic [4:0] wr_count(input logic ext,
                                          input logic [2:0] code);
    logic [4:0] v;
    v = 5'h00;
    if (ext) begin
      case (code)
        3'h0: v = 5'h0A;
        3'h1: v = 5'h0B;
        3'h2: v = 5'h0C;
        3'h4: v = 5'h0E;
        3'h6: v = 5'h10;
        default: v = 5'h00;
      endcase
    end else begin
      case (code)
        3'h4: v = 5'h06;
        3'h6: v = 5'h08;
        3'h7: v = 5'h09;
        default: v = 5'h00;
      endcase
    end
    return v;
  endfunction

  function automatic logic lat_ok(input logic [3:0] c);
    return c == 4'h4 || c == 4'h6 || c == 4'h7 || c == 4'h8 ||
           c == 4'h9 || c == 4'hA || c == 4'hC;
  endfunction

  function automatic logic drive_ok(input logic [3:0] c);
    return c == 4'h1 || c == 4'h2 || c == 4'h3 || c == 4'h4 ||
           c == 4'h6 || c == 4'h9 || c == 4'hA || c == 4'hB;
  endfunction

  function automatic logic cal_ok(input logic [7:0] c);
    return c == CAL_INIT || c == CAL_LONG || c == CAL_SHORT ||
           c == CAL_RESET;
  endfunction

  assign wr_hit = mode_reg_write_cmd;
  assign soft_rst = wr_hit && reg_addr == ADDR_SOFT_RESET;

  // Feature one: only the burst-of-eight code is ever stored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      feat1_r <= '{WR_RECOVERY_RESET, 2'h0, BURST_EIGHT};
    end else if (soft_rst) begin
      feat1_r <= '{WR_RECOVERY_RESET, 2'h0, BURST_EIGHT};
    end else if (wr_hit && reg_addr == ADDR_FEATURE_ONE) begin
      feat1_r.write_recovery_cycles <= write_data[7:5];
      feat1_r.burst_length_sel <= BURST_EIGHT;
    end
  end

  // Reserved latency codes are refused, so the old pair stays; the set B bit is ignored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      feat2_r <= '{1'b0, 1'b0, 1'b0, WR_EXTEND_RESET, LATENCY_RESET};
    end else if (soft_rst) begin
      feat2_r <= '{1'b0, 1'b0, 1'b0, WR_EXTEND_RESET, LATENCY_RESET};
    end else if (wr_hit && reg_addr == ADDR_FEATURE_TWO) begin
      if (lat_ok(write_data[3:0])) begin
        feat2_r.latency_sel <= write_data[3:0];
      end
      feat2_r.write_recovery_extend <= write_data[4];
      feat2_r.write_level_en <= write_data[7];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      drive_strength_sel <= DRIVE_RESET;
    end else if (soft_rst) begin
      drive_strength_sel <= DRIVE_RESET;
    end else if (wr_hit && reg_addr == ADDR_IO_DRIVE &&
                 drive_ok(write_data[3:0])) begin
      drive_strength_sel <= write_data[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_termination_sel <= TERM_RESET;
      powerdown_termination_keep <= 1'b0;
    end else if (soft_rst) begin
      data_termination_sel <= TERM_RESET;
      powerdown_termination_keep <= 1'b0;
    end else if (wr_hit && reg_addr == ADDR_TERMINATION) begin
      data_termination_sel <= write_data[1:0];
      powerdown_termination_keep <= write_data[2];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bank_refresh_block <= MASK_RESET;
      segment_refresh_block <= MASK_RESET;
    end else if (soft_rst) begin
      bank_refresh_block <= MASK_RESET;
      segment_refresh_block <= MASK_RESET;
    end else if (wr_hit && reg_addr == ADDR_BANK_MASK) begin
      bank_refresh_block <= write_data;
    end else if (wr_hit && reg_addr == ADDR_SEGMENT_MASK) begin
      segment_refresh_block <= write_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ca_training <= 1'b0;
    end else if (soft_rst) begin
      ca_training <= 1'b0;
    end else if (wr_hit && (reg_addr == ADDR_CA_ENTER_ONE ||
                            reg_addr == ADDR_CA_ENTER_THREE)) begin
      ca_training <= 1'b1;
    end else if (wr_hit && reg_addr == ADDR_CA_EXIT) begin
      ca_training <= 1'b0;
    end
  end

  // Self-test outcome latched only by the init calibration command;
  // a failed pin also freezes the trim for later calibrations until a reset or soft reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      selftest_r <= SELFTEST_NOT_RUN;
      cal_start <= 1'b0;
      cal_code <= 8'h00;
      use_factory_trim <= 1'b0;
    end else begin
      cal_start <= 1'b0;
      if (soft_rst) begin
        selftest_r <= SELFTEST_NOT_RUN;
        use_factory_trim <= 1'b0;
      end else if (wr_hit && reg_addr == ADDR_CALIBRATION &&
                   cal_ok(write_data)) begin
        if (write_data == CAL_INIT) begin
          if (zq_pin_to_supply) begin
            selftest_r <= SELFTEST_PIN_HIGH;
            use_factory_trim <= 1'b1;
          end else if (zq_pin_to_ground) begin
            selftest_r <= SELFTEST_PIN_LOW;
            use_factory_trim <= 1'b1;
          end else begin
            selftest_r <= SELFTEST_PASSED;
          end
        end
        if (!use_factory_trim && !(write_data == CAL_INIT &&
            (zq_pin_to_supply || zq_pin_to_ground))) begin
          cal_start <= 1'b1;
          cal_code <= write_data;
        end
      end
    end
  end

  // Init timer restarts on the reset command and finishes at the 10 us mark
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      init_cnt_r <= 16'h0000;
      auto_init_pending <= 1'b1;
    end else if (soft_rst) begin
      init_cnt_r <= 16'h0000;
      auto_init_pending <= 1'b1;
    end else if (auto_init_pending) begin
      if (init_cnt_r == 16'(INIT_CYCLES - 1)) begin
        auto_init_pending <= 1'b0;
      end else begin
        init_cnt_r <= init_cnt_r + 16'h0001;
      end
    end
  end

  // Update flag: a change in the same cycle as a read still sets it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mult_r <= 3'h3;
      tuf_r <= 1'b0;
    end else begin
      mult_r <= refresh_multiplier_in;
      if (refresh_multiplier_in != mult_r) begin
        tuf_r <= 1'b1;
      end else if (mode_reg_read_cmd && reg_addr == ADDR_REFRESH_RATE) begin
        tuf_r <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_nxt = 8'h00;
    case (reg_addr)
      ADDR_DEVICE_INFO:
        rd_nxt = {3'h0, selftest_r, 2'h0, auto_init_pending};
      ADDR_REFRESH_RATE: rd_nxt = {tuf_r, 4'h0, mult_r};
      ADDR_MAKER_CODE: rd_nxt = MAKER_ID;
      ADDR_REVISION_ONE: rd_nxt = REVISION_ID1;
      ADDR_REVISION_TWO: rd_nxt = REVISION_ID2;
      ADDR_GEOMETRY: rd_nxt = {GEOM_WIDTH, GEOM_DENSITY, GEOM_TYPE};
      ADDR_DQ_PATTERN_A: rd_nxt = PATTERN_A;
      ADDR_DQ_PATTERN_B: rd_nxt = PATTERN_B;
      default: rd_nxt = 8'h00;
    endcase
  end

  // Every read answers with a strobe pair, readable or not
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      read_data <= 8'h00;
      read_valid <= 1'b0;
      strobe_t <= 1'b0;
      strobe_c <= 1'b1;
    end else begin
      read_valid <= mode_reg_read_cmd;
      strobe_t <= mode_reg_read_cmd;
      strobe_c <= !mode_reg_read_cmd;
      if (mode_reg_read_cmd) begin
        read_data <= rd_nxt;
      end
    end
  end

  // Burst walker: wraps within eight, start column bit 0 forced low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      burst_idx_r <= 3'h0;
      burst_col <= 3'h0;
    end else if (burst_step) begin
      burst_idx_r <= burst_idx_r + 3'h1;
      burst_col <= burst_idx_r + 3'h1;
    end else begin
      burst_idx_r <= {burst_start_col[2:1], 1'b0};
      burst_col <= {burst_start_col[2:1], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      write_recovery_cycles_o <= WR_RECOVERY_RESET;
      wr_recovery_count <= 5'h0A;
      read_latency <= 4'hA;
      write_latency <= 4'h6;
      write_level_en <= 1'b0;
      derate_needed <= 1'b0;
    end else begin
      write_recovery_cycles_o <= feat1_r.write_recovery_cycles;
      wr_recovery_count <= wr_count(feat2_r.write_recovery_extend,
                                    feat1_r.write_recovery_cycles);
      write_level_en <= feat2_r.write_level_en;
      derate_needed <= mult_r == 3'h6;
      case (feat2_r.latency_sel)
        4'h4: begin read_latency <= 4'h6; write_latency <= 4'h3; end
        4'h6: begin read_latency <= 4'h8; write_latency <= 4'h4; end
        4'h7: begin read_latency <= 4'h9; write_latency <= 4'h5; end
        4'h9: begin read_latency <= 4'hB; write_latency <= 4'h6; end
        4'hA: begin read_latency <= 4'hC; write_latency <= 4'h6; end
        4'hC: begin read_latency <= 4'hE; write_latency <= 4'h8; end
        default: begin read_latency <= 4'hA; write_latency <= 4'h6; end
      endcase
    end
  end

  // A read of the rate register, the event that may clear the flag
  sequence s_rate_read;
    mode_reg_read_cmd && reg_addr == ADDR_REFRESH_RATE;
  endsequence

  // A write to the read-only device info register never alters configuration
  a_ro_write_inert: assert property (disable iff (!rstn)
    wr_hit && reg_addr == ADDR_DEVICE_INFO
    |=> $stable({feat1_r, feat2_r, selftest_r}))
    else $error("read-only write altered state");
  a_tuf_clear: assert property (disable iff (!rstn)
    s_rate_read ##0 (refresh_multiplier_in == mult_r) |=> !tuf_r)
    else $error("update flag not cleared");
  a_tuf_set: assert property (disable iff (!rstn)
    refresh_multiplier_in != mult_r |=> tuf_r)
    else $error("update flag not set");
  a_strobe_read: assert property (disable iff (!rstn)
    mode_reg_read_cmd |=> read_valid && strobe_t && !strobe_c)
    else $error("strobes idle on read");
  a_ca_train: assert property (disable iff (!rstn)
    wr_hit && reg_addr == ADDR_CA_EXIT |=> !ca_training)
    else $error("training not left");
  a_burst_len: assert property (disable iff (!rstn)
    feat1_r.burst_length_sel == BURST_EIGHT)
    else $error("burst code corrupted");
  a_bad_cal: assert property (disable iff (!rstn)
    wr_hit && reg_addr == ADDR_CALIBRATION && !cal_ok(write_data)
    |=> !cal_start)
    else $error("reserved calibration started");
  a_trim_lock: assert property (disable iff (!rstn)
    use_factory_trim && !soft_rst |=> !cal_start)
    else $error("calibration after failed self-test");
endmodule
`default_nettype wire

// ---- rtl/mode_reg_pkg.sv ----
// Package: offsets, field layouts, reset codes and timing for the mode
// register file. Assumes a single 200 MHz command clock.
package mode_reg_pkg;
  localparam logic [7:0] ADDR_DEVICE_INFO = 8'h00;
  localparam logic [7:0] ADDR_FEATURE_ONE = 8'h01;
  localparam logic [7:0] ADDR_FEATURE_TWO = 8'h02;
  localparam logic [7:0] ADDR_IO_DRIVE = 8'h03;
  localparam logic [7:0] ADDR_REFRESH_RATE = 8'h04;
  localparam logic [7:0] ADDR_MAKER_CODE = 8'h05;
  localparam logic [7:0] ADDR_REVISION_ONE = 8'h06;
  localparam logic [7:0] ADDR_REVISION_TWO = 8'h07;
  localparam logic [7:0] ADDR_GEOMETRY = 8'h08;
  localparam logic [7:0] ADDR_CALIBRATION = 8'h0A;
  localparam logic [7:0] ADDR_TERMINATION = 8'h0B;
  localparam logic [7:0] ADDR_BANK_MASK = 8'h10;
  localparam logic [7:0] ADDR_SEGMENT_MASK = 8'h11;
  localparam logic [7:0] ADDR_DQ_PATTERN_A = 8'h20;
  localparam logic [7:0] ADDR_DQ_PATTERN_B = 8'h28;
  localparam logic [7:0] ADDR_CA_ENTER_ONE = 8'h29;
  localparam logic [7:0] ADDR_CA_EXIT = 8'h2A;
  localparam logic [7:0] ADDR_CA_ENTER_THREE = 8'h30;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h3F;

  localparam logic [2:0] BURST_EIGHT = 3'h3;
  localparam logic [2:0] WR_RECOVERY_RESET = 3'h0;
  localparam logic [3:0] LATENCY_RESET = 4'h8;
  localparam logic WR_EXTEND_RESET = 1'b1;
  localparam logic [3:0] DRIVE_RESET = 4'h2;
  localparam logic [1:0] TERM_RESET = 2'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;

  localparam logic [1:0] SELFTEST_NOT_RUN = 2'h0;
  localparam logic [1:0] SELFTEST_PIN_HIGH = 2'h1;
  localparam logic [1:0] SELFTEST_PIN_LOW = 2'h2;
  localparam logic [1:0] SELFTEST_PASSED = 2'h3;

  // Calibration command codes
  localparam logic [7:0] CAL_INIT = 8'hFF;
  localparam logic [7:0] CAL_LONG = 8'hAB;
  localparam logic [7:0] CAL_SHORT = 8'h56;
  localparam logic [7:0] CAL_RESET = 8'hC3;

  localparam logic [1:0] GEOM_TYPE = 2'h3;
  localparam logic [3:0] GEOM_DENSITY = 4'h5;
  localparam logic [1:0] GEOM_WIDTH = 2'h0;
  // Arbitrary identity values
  localparam logic [7:0] MAKER_ID = 8'h5A;
  localparam logic [7:0] REVISION_ID1 = 8'h01;
  localparam logic [7:0] REVISION_ID2 = 8'h00;
  localparam logic [7:0] PATTERN_A = 8'h55;
  localparam logic [7:0] PATTERN_B = 8'h3C;

  localparam int CLK_MHZ = 200;
  localparam int INIT_TIME_US = 10;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic [2:0] write_recovery_cycles;
    logic [1:0] reserved_future;
    logic [2:0] burst_length_sel;
  } feature_one_t;

  typedef struct packed {
    logic write_level_en;
    logic write_latency_set;
    logic reserved_future;
    logic write_recovery_extend;
    logic [3:0] latency_sel;
  } feature_two_t;

  typedef struct packed {
    logic [2:0] read_latency;
    logic [4:0] unused_hi;
  } dummy_t;
endpackage

// ---- dv/mode_reg_ctrl_model.sv ----
// Controller model: issues mode register reads and writes on request.
// Assumes the bench calls wr and rd from one process, never overlapping.
`timescale 1ns/1ps
`default_nettype none
module mode_reg_ctrl_model (
  input wire logic mclk,
  input wire logic derate_needed,
  output logic mode_reg_write_cmd,
  output logic mode_reg_read_cmd,
  output logic [7:0] reg_addr,
  output logic [7:0] write_data,
  output logic derate_timing
);
  import mode_reg_pkg::*;

  // Core timings get stretched while the device asks for it
  assign derate_timing = derate_needed;

  initial begin
    mode_reg_write_cmd = 1'b0;
    mode_reg_read_cmd = 1'b0;
    reg_addr = 8'hA5;
    write_data = 8'h5A;
  end

  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    case (a)
      ADDR_FEATURE_ONE: keep_mask = 8'hE7;
      ADDR_FEATURE_TWO: keep_mask = 8'h9F;
      ADDR_IO_DRIVE: keep_mask = 8'h0F;
      ADDR_TERMINATION: keep_mask = 8'h07;
      default: keep_mask = 8'hFF;
    endcase
  endfunction

  // Raw writes bypass the masking; only the bench asks for them
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic raw);
    @(posedge mclk);
    #1;
    mode_reg_write_cmd = 1'b1;
    reg_addr = a;
    write_data = raw ? d : (d & keep_mask(a));
    if (!raw && a == ADDR_FEATURE_ONE) begin
      write_data[2:0] = BURST_EIGHT;
    end
    @(posedge mclk);
    #1;
    mode_reg_write_cmd = 1'b0;
    reg_addr = ~reg_addr;
    write_data = ~write_data;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    #1;
    mode_reg_read_cmd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    mode_reg_read_cmd = 1'b0;
    reg_addr = ~reg_addr;
  endtask
endmodule
`default_nettype wire

// ---- dv/dram_mode_register_file_tb.sv ----
// Bench for the mode register file: drives it through the controller model.
// Assumes a 200 MHz clock and the full 2000-cycle init count.
`timescale 1ns/1ps
`default_nettype none
module dram_mode_register_file_tb;
  import mode_reg_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic mode_reg_write_cmd, mode_reg_read_cmd, read_valid, strobe_t;
  logic [7:0] reg_addr, write_data, read_data, cal_code;
  logic [2:0] refresh_multiplier_in = 3'h3;
  logic zq_pin_to_supply = 1'b0;
  logic zq_pin_to_ground = 1'b0;
  logic [2:0] burst_start_col = 3'h0;
  logic burst_step = 1'b0;
  logic strobe_c, auto_init_pending, write_level_en, use_factory_trim;
  logic cal_start, powerdown_termination_keep, ca_training;
  logic derate_needed, derate_timing;
  logic [2:0] write_recovery_cycles_o, burst_col, p;
  logic [4:0] wr_recovery_count;
  logic [3:0] read_latency, write_latency, drive_strength_sel;
  logic [1:0] data_termination_sel;
  logic [7:0] bank_refresh_block, segment_refresh_block;
  logic [31:0] seed = 32'h7716;
  logic [31:0] r;
  int err_count = 0;
  int tests_run = 0;
  logic [3:0] lat_code [7] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC};
  logic [3:0] rl_exp [7] = '{4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE};
  logic [3:0] wl_exp [7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h6, 4'h6, 4'h8};
  logic [2:0] wr_code [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h4, 3'h6, 3'h7};
  logic [4:0] wr_exp [8] = '{5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10, 5'h06,
                             5'h08, 5'h09};
  logic [3:0] ds_code [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h9, 4'hA, 4'hB};
  logic [7:0] ca_addr [4] = '{8'h29, 8'h2A, 8'h30, 8'h2A};

  always #2.5 mclk = ~mclk;

  dram_mode_register_file i_dram_mode_register_file (.mclk, .rstn,
    .mode_reg_write_cmd, .mode_reg_read_cmd, .reg_addr, .write_data,
    .refresh_multiplier_in, .zq_pin_to_supply, .zq_pin_to_ground,
    .burst_start_col, .burst_step, .read_data, .read_valid, .strobe_t,
    .strobe_c, .auto_init_pending, .write_recovery_cycles_o,
    .wr_recovery_count, .read_latency, .write_latency, .write_level_en,
    .drive_strength_sel, .use_factory_trim, .cal_start, .cal_code,
    .data_termination_sel, .powerdown_termination_keep,
    .bank_refresh_block, .segment_refresh_block, .ca_training,
    .burst_col, .derate_needed);

  mode_reg_ctrl_model i_mode_reg_ctrl_model (.mclk, .derate_needed,
    .mode_reg_write_cmd, .mode_reg_read_cmd, .reg_addr, .write_data,
    .derate_timing);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic final_report();
    $display("errors %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Latency and recovery outputs land two edges after the write
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_mode_reg_ctrl_model.wr(a, d, 1'b0);
    settle();
  endtask

  task automatic rd(input logic [7:0] a);
    i_mode_reg_ctrl_model.rd(a);
    chk({read_valid, strobe_t, strobe_c}, 8'h06);
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (20) @(posedge mclk);
    #1;
    rstn = 1'b1;
  endtask

  task automatic wait_init();
    int n;
    n = 0;
    while (auto_init_pending !== 1'b0 && n < INIT_CYCLES + 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= INIT_CYCLES + 8) begin
      err_count++;
      final_report();
    end
  endtask

  task automatic check_defaults();
    chk(read_latency, 8'h0A);
    chk(write_latency, 8'h06);
    chk(wr_recovery_count, 8'h0A);
    chk(drive_strength_sel, 8'h02);
    chk({powerdown_termination_keep, data_termination_sel}, 8'h00);
    chk(bank_refresh_block | segment_refresh_block, 8'h00);
    chk({write_level_en, ca_training}, 8'h00);
  endtask

  // A missed pulse and a doubled one both show up in the count
  task automatic cal(input logic [7:0] code, input logic go);
    int n;
    n = 0;
    i_mode_reg_ctrl_model.wr(ADDR_CALIBRATION, code, 1'b1);
    repeat (4) begin
      n += (cal_start === 1'b1);
      @(posedge mclk);
      #1;
    end
    chk(8'(n), {7'h0, go});
    if (go) chk(cal_code, code);
  endtask

  initial begin
    do_reset();
    check_defaults();
    rd(ADDR_DEVICE_INFO);
    chk(read_data, 8'h01);
    wait_init();
    rd(ADDR_DEVICE_INFO);
    chk(read_data, 8'h00);
    rd(8'h09);
    rd(8'h40);
    rd(ADDR_FEATURE_ONE);
    r = rnd();
    wr(ADDR_GEOMETRY, r[7:0]);
    wr(ADDR_MAKER_CODE, r[15:8]);
    wr(ADDR_DEVICE_INFO, r[23:16]);
    rd(ADDR_GEOMETRY);
    chk(read_data, 8'h17);
    rd(ADDR_MAKER_CODE);
    chk(read_data, MAKER_ID);
    rd(ADDR_DEVICE_INFO);
    chk(read_data, 8'h00);
    for (int i = 0; i < 7; i++) begin
      r = rnd();
      wr(ADDR_FEATURE_TWO, {r[0], 3'h1, lat_code[i]});
      chk(read_latency, rl_exp[i]);
      chk(write_latency, wl_exp[i]);
      chk(write_level_en, r[0]);
    end
    wr(ADDR_FEATURE_TWO, 8'h11);
    chk({read_latency, write_latency}, 8'hE8);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_FEATURE_TWO, {3'h0, i < 5, 4'h8});
      wr(ADDR_FEATURE_ONE, {wr_code[i], 5'h03});
      chk(wr_recovery_count, wr_exp[i]);
      chk(write_recovery_cycles_o, wr_code[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_IO_DRIVE, {4'h0, ds_code[i]});
      chk(drive_strength_sel, ds_code[i]);
    end
    wr(ADDR_IO_DRIVE, 8'h05);
    chk(drive_strength_sel, 8'h0B);
    repeat (4) begin
      r = rnd();
      wr(ADDR_TERMINATION, r[7:0]);
      wr(ADDR_BANK_MASK, r[15:8]);
      wr(ADDR_SEGMENT_MASK, r[23:16]);
      chk({powerdown_termination_keep, data_termination_sel}, r[2:0]);
      chk(bank_refresh_block, r[15:8]);
      chk(segment_refresh_block, r[23:16]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ca_addr[i], 8'h00);
      chk(ca_training, {7'h0, ~i[0]});
    end
    rd(ADDR_REFRESH_RATE);
    for (int i = 0; i < 8; i++) begin
      refresh_multiplier_in = i[2:0];
      settle();
      rd(ADDR_REFRESH_RATE);
      chk(read_data, {5'h10, i[2:0]});
      rd(ADDR_REFRESH_RATE);
      chk(read_data, {5'h00, i[2:0]});
      chk(derate_timing, {7'h0, i == 6});
    end
    cal(CAL_INIT, 1'b1);
    rd(ADDR_DEVICE_INFO);
    chk(read_data, 8'h18);
    chk(use_factory_trim, 8'h00);
    cal(8'h12, 1'b0);
    cal(CAL_SHORT, 1'b1);
    r = rnd();
    burst_start_col = r[2:0] | 3'h1;
    settle();
    chk(burst_col, {r[2:1], 1'b0});
    burst_step = 1'b1;
    repeat (7) begin
      p = burst_col;
      @(posedge mclk);
      #1;
      chk(burst_col, 3'(p + 3'h1));
    end
    burst_step = 1'b0;
    wr(ADDR_SOFT_RESET, 8'hFC);
    check_defaults();
    rd(ADDR_DEVICE_INFO);
    chk(read_data, 8'h01);
    for (int k = 1; k < 3; k++) begin
      zq_pin_to_supply = (k == 1);
      zq_pin_to_ground = (k == 2);
      do_reset();
      check_defaults();
      wait_init();
      cal(CAL_INIT, 1'b0);
      rd(ADDR_DEVICE_INFO);
      chk(read_data, {3'h0, k[1:0], 3'h0});
      chk(use_factory_trim, 8'h01);
      cal(CAL_LONG, 1'b0);
    end
    final_report();
  end
endmodule
`default_nettype wire
